//--- agcsw_cfg.svh
`ifndef AGCSW_CFG_SVH
`define AGCSW_CFG_SVH
// register byte offsets on the apb side
`define AGC_A_CTRL      8'h00
`define AGC_A_SEL       8'h04
`define AGC_A_WPOS      8'h08
`define AGC_A_WSIZE     8'h0C
`define AGC_A_OPOS      8'h10
`define AGC_A_OSIZE     8'h14
`define AGC_A_LIMIT     8'h18
`define AGC_A_TARGET    8'h1C
`define AGC_A_MANUAL    8'h20
`define AGC_A_STATUS    8'h24
// control fields
`define AGC_F_MODE      1:0
`define AGC_F_FMT12     4
`define AGC_F_BIN       5
`define AGC_F_NOLIM     6
`define AGC_F_PROF      8
`define AGC_F_ALIGN     1:0
// paired registers: x, width, floor low half; y, height, ceiling high half
`define AGC_HI_LSB      16
// gain legal maxima per setup
`define AGC_GMAX_8      10'h200
`define AGC_GMAX_12     10'h180
`define AGC_GMAX_BIN    10'h100
`define AGC_GMAX_ABS    10'h3FF
// target mean maxima, reset target, match tolerance
`define AGC_TMAX_8      12'h0FF
`define AGC_TMAX_12     12'hFFF
`define AGC_TGT_RST     12'h080
`define AGC_TOL         12'h002
// once mode gives up after this many images (30)
`define AGC_ONCE_MAX    5'h1E
// sensor size, frame time separating fast from slow rates
`define AGC_SENSOR_W    12'h780
`define AGC_SENSOR_H    12'h438
`define AGC_FAST_FRAME_NS 32'h0098_9680
`define AGC_CLK_NS      32'h0000_0064
`endif

//--- agcsw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface agcsw_link_if #(
    parameter int GW = 10,
    parameter int DW = 12
) ();
    logic [DW-1:0] mean;
    logic          meanValid;
    logic [DW-1:0] target;
    logic [GW-1:0] floorG;
    logic [GW-1:0] ceilG;
    logic [GW-1:0] curGain;
    logic [GW-1:0] stepGain;
    logic          stepValid;
    logic          matched;
    modport stat (output mean, meanValid);
    modport step (input mean, meanValid, target, floorG, ceilG, curGain,
                  output stepGain, stepValid, matched);
endinterface : agcsw_link_if
`default_nettype wire

//--- agcsw_pkg.sv
package agcsw_pkg;
    // register codes 0, 1, 2 follow declaration order
    typedef enum logic [1:0] {AGCSW_OFF, AGCSW_ONCE, AGCSW_CONT} agcsw_mode_t;
    typedef logic [11:0] agcsw_coord_t;
    typedef struct packed {
        agcsw_coord_t x;
        agcsw_coord_t y;
        agcsw_coord_t w;
        agcsw_coord_t h;
    } agcsw_win_t;

    // one extra bit so offset plus size cannot wrap
    function automatic logic agcsw_in_win(input agcsw_coord_t c,
                                          input agcsw_coord_t r,
                                          input agcsw_win_t   a);
        agcsw_in_win = (c >= a.x) && ({1'b0, c} < {1'b0, a.x} + {1'b0, a.w})
                    && (r >= a.y) && ({1'b0, r} < {1'b0, a.y} + {1'b0, a.h});
    endfunction : agcsw_in_win

    function automatic logic agcsw_overlap(input agcsw_win_t a,
                                           input agcsw_win_t b);
        agcsw_overlap = ({1'b0, a.x} < {1'b0, b.x} + {1'b0, b.w})
                     && ({1'b0, b.x} < {1'b0, a.x} + {1'b0, a.w})
                     && ({1'b0, a.y} < {1'b0, b.y} + {1'b0, b.h})
                     && ({1'b0, b.y} < {1'b0, a.y} + {1'b0, a.h});
    endfunction : agcsw_overlap
endpackage : agcsw_pkg

//--- agcsw_stat.sv
`timescale 1ns/1ps
`default_nettype none
module agcsw_stat
    import agcsw_pkg::*;
#(
    parameter int DW = 12,
    parameter int NW = 24
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          frameStart,
    input  wire logic          lineEnd,
    input  wire logic          pixValid,
    input  wire logic [DW-1:0] pixData,
    input  wire agcsw_win_t    statWin,
    input  wire agcsw_win_t    outWin,
    agcsw_link_if.stat         link
);
    typedef struct packed {
        agcsw_coord_t     col;
        agcsw_coord_t     row;
        logic [DW+NW-1:0] sum;
        logic [NW-1:0]    cnt;
        logic [DW-1:0]    mean;
        logic             valid;
    } agcsw_stat_t;

    agcsw_stat_t st_ff;
    agcsw_stat_t nxt_st;
    logic        hit;

    // coordinates count delivered pixels, so binned streams give binned units
    always_comb begin
        nxt_st = st_ff;
        hit = pixValid && agcsw_in_win(st_ff.col, st_ff.row, statWin)
                       && agcsw_in_win(st_ff.col, st_ff.row, outWin);
        nxt_st.valid = 1'b0;
        if (frameStart) begin
            // one mean per frame, none if no pixel fell inside
            nxt_st.valid = (st_ff.cnt != '0);
            if (st_ff.cnt != '0)
                nxt_st.mean = DW'(st_ff.sum / (DW+NW)'(st_ff.cnt));
            nxt_st.sum = '0;
            nxt_st.cnt = '0;
            nxt_st.col = '0;
            nxt_st.row = '0;
        end else begin
            if (pixValid)
                nxt_st.col = st_ff.col + 12'h001;
            if (hit) begin
                nxt_st.sum = st_ff.sum + (DW+NW)'(pixData);
                nxt_st.cnt = st_ff.cnt + NW'(1);
            end
            if (lineEnd) begin
                nxt_st.col = '0;
                nxt_st.row = st_ff.row + 12'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign link.mean      = st_ff.mean;
    assign link.meanValid = st_ff.valid;
endmodule : agcsw_stat
`default_nettype wire

//--- agcsw_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "agcsw_cfg.svh"
module agcsw_step
    import agcsw_pkg::*;
#(
    parameter int GW = 10,
    parameter int DW = 12
) (
    input  wire logic  clk,
    input  wire logic  rstn,
    agcsw_link_if.step link
);
    typedef struct packed {
        logic [GW-1:0] gain;
        logic          valid;
        logic          matched;
    } agcsw_step_t;

    agcsw_step_t st_ff;
    agcsw_step_t nxt_st;
    logic        below;
    logic        above;

    // one code step per mean, then clamped to floor and ceiling
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = link.meanValid;
        below = ({1'b0, link.mean} + {1'b0, DW'(`AGC_TOL)}) < {1'b0, link.target};
        above = {1'b0, link.mean} > ({1'b0, link.target} + {1'b0, DW'(`AGC_TOL)});
        if (link.meanValid) begin
            nxt_st.gain = link.curGain;
            if (below && link.curGain < link.ceilG)
                nxt_st.gain = link.curGain + GW'(1);
            else if (above && link.curGain > link.floorG)
                nxt_st.gain = link.curGain - GW'(1);
            if (nxt_st.gain > link.ceilG)
                nxt_st.gain = link.ceilG;
            if (nxt_st.gain < link.floorG)
                nxt_st.gain = link.floorG;
            nxt_st.matched = !below && !above;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign link.stepGain  = st_ff.gain;
    assign link.stepValid = st_ff.valid;
    assign link.matched   = st_ff.matched;
endmodule : agcsw_step
`default_nettype wire

//--- agcsw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "agcsw_cfg.svh"
// What this block does
// - reset windows cover the full sensor
// - offsets are first column and row
// - geometry accepted in single-pixel steps
// - binned streams give binned window units
// - auto mode steps gain toward target mean
// - modes are off, once and continuous
// - no overlap means manual gain applies
// - auto-stepped gain stays between floor and ceiling; manual gain is not clamped
// - limit range follows format, binning, override
// - target spans 8-bit or 12-bit range
// - once ends on match or 30 images
// - continuous adjusts every or every other image
// - statistics only from window intersection
module agcsw_top
    import agcsw_pkg::*;
#(
    parameter int           GW             = 10,
    parameter int           DW             = 12,
    parameter int           FAST_FRAME_CYC = `AGC_FAST_FRAME_NS / `AGC_CLK_NS,
    parameter agcsw_coord_t SENSOR_W       = `AGC_SENSOR_W,
    parameter agcsw_coord_t SENSOR_H       = `AGC_SENSOR_H
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          frameStart,
    input  wire logic          lineEnd,
    input  wire logic          pixValid,
    input  wire logic [DW-1:0] pixData,
    output logic [GW-1:0]      gainCode,
    output agcsw_mode_t        autoMode,
    output logic               minimizeExposure
);
    localparam int CW = $bits(agcsw_coord_t);

    typedef struct packed {
        agcsw_mode_t      mode;
        logic             fmt12;
        logic             bin;
        logic             noLim;
        logic             prof;
        logic             sel;
        agcsw_win_t [1:0] win;
        agcsw_win_t       owin;
        logic [GW-1:0]    floorG;
        logic [GW-1:0]    ceilG;
        logic [DW-1:0]    target;
        logic [GW-1:0]    manual;
        logic [GW-1:0]    pend;
        logic [GW-1:0]    gain;
        logic [4:0]       onceCnt;
        logic             parity;
        logic [23:0]      frameCyc;
        logic             fast;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } agcsw_top_t;

    localparam agcsw_win_t FULL_WIN = '{x: '0, y: '0, w: SENSOR_W, h: SENSOR_H};
    localparam agcsw_top_t RST_ST = '{
        mode:    AGCSW_OFF,
        win:     {FULL_WIN, FULL_WIN},
        owin:    FULL_WIN,
        ceilG:   GW'(`AGC_GMAX_8),
        target:  DW'(`AGC_TGT_RST),
        default: '0
    };

    agcsw_top_t  st_ff;
    agcsw_top_t  nxt_st;
    logic        ovl;
    logic        setup;
    logic        commit;
    logic        mapped;
    logic        onceTick;
    logic        doAdj;
    logic [31:0] rdVal;

    agcsw_link_if #(.GW(GW), .DW(DW)) link ();

    agcsw_stat #(.DW(DW)) u_stat (
        .clk        (clk),
        .rstn       (rstn),
        .frameStart (frameStart),
        .lineEnd    (lineEnd),
        .pixValid   (pixValid),
        .pixData    (pixData),
        .statWin    (st_ff.win[0]),
        .outWin     (st_ff.owin),
        .link       (link.stat)
    );

    agcsw_step #(.GW(GW), .DW(DW)) u_step (
        .clk  (clk),
        .rstn (rstn),
        .link (link.step)
    );

    assign link.target  = st_ff.target;
    assign link.floorG  = st_ff.floorG;
    assign link.ceilG   = st_ff.ceilG;
    assign link.curGain = st_ff.pend;

    // legal ceiling for the limit registers under the current setup
    function automatic logic [GW-1:0] gainMax(input logic f12,
                                              input logic b,
                                              input logic nl);
        if (nl)
            gainMax = GW'(`AGC_GMAX_ABS);
        else if (b)
            gainMax = GW'(`AGC_GMAX_BIN);
        else if (f12)
            gainMax = GW'(`AGC_GMAX_12);
        else
            gainMax = GW'(`AGC_GMAX_8);
    endfunction : gainMax

    // target and limits share this clamp
    function automatic logic [15:0] clampTo(input logic [15:0] v,
                                            input logic [15:0] lim);
        clampTo = (v > lim) ? lim : v;
    endfunction : clampTo

    // gain uses the first window against the output window
    assign ovl = agcsw_overlap(st_ff.win[0], st_ff.owin);

    // apb phases: first access cycle decodes, second completes
    assign setup  = psel && penable && !st_ff.pready;
    assign commit = psel && penable && st_ff.pready;
    assign mapped = (paddr[`AGC_F_ALIGN] == '0) && (paddr <= `AGC_A_STATUS);

    // read mux
    always_comb begin
        unique case (paddr)
            `AGC_A_CTRL:   rdVal = 32'({st_ff.prof, 1'b0, st_ff.noLim, st_ff.bin,
                                        st_ff.fmt12, 2'b00, st_ff.mode});
            `AGC_A_SEL:    rdVal = 32'(st_ff.sel);
            `AGC_A_WPOS:   rdVal = {16'(st_ff.win[st_ff.sel].y), 16'(st_ff.win[st_ff.sel].x)};
            `AGC_A_WSIZE:  rdVal = {16'(st_ff.win[st_ff.sel].h), 16'(st_ff.win[st_ff.sel].w)};
            `AGC_A_OPOS:   rdVal = {16'(st_ff.owin.y), 16'(st_ff.owin.x)};
            `AGC_A_OSIZE:  rdVal = {16'(st_ff.owin.h), 16'(st_ff.owin.w)};
            `AGC_A_LIMIT:  rdVal = {16'(st_ff.ceilG), 16'(st_ff.floorG)};
            `AGC_A_TARGET: rdVal = 32'(st_ff.target);
            `AGC_A_MANUAL: rdVal = 32'(st_ff.manual);
            `AGC_A_STATUS: rdVal = {16'(link.mean), 16'(st_ff.gain)};
            default:       rdVal = '0;
        endcase
    end

    // frame pacing, gain stepping, then software writes (software wins)
    always_comb begin
        nxt_st = st_ff;
        doAdj = 1'b0;
        onceTick = 1'b0;
        nxt_st.pready = setup;
        if (setup) begin
            nxt_st.pslverr = !mapped;
            nxt_st.prdata = (pwrite || !mapped) ? '0 : rdVal;
        end
        if (commit) begin
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata = '0;
        end
        // frame length decides the continuous rate
        if (frameStart) begin
            nxt_st.fast = st_ff.frameCyc < 24'(FAST_FRAME_CYC);
            nxt_st.frameCyc = '0;
            nxt_st.gain = st_ff.pend;
            if (st_ff.mode != AGCSW_OFF && !ovl)
                nxt_st.pend = st_ff.manual;
        end else if (st_ff.frameCyc != '1) begin
            nxt_st.frameCyc = st_ff.frameCyc + 24'h00_0001;
        end
        // a fresh step lands in the pending code for the next frame
        if (link.stepValid && ovl && st_ff.mode != AGCSW_OFF) begin
            doAdj = (st_ff.mode == AGCSW_ONCE) || !st_ff.fast || st_ff.parity;
            nxt_st.parity = !st_ff.parity;
            if (doAdj)
                nxt_st.pend = link.stepGain;
        end
        // once counts images even when statistics are unusable
        onceTick = (st_ff.mode == AGCSW_ONCE)
                && ((link.stepValid && ovl) || (frameStart && !ovl));
        if (onceTick) begin
            if ((link.stepValid && ovl && link.matched)
                    || st_ff.onceCnt == `AGC_ONCE_MAX - 5'h01) begin
                nxt_st.mode = AGCSW_OFF;
                nxt_st.onceCnt = '0;
            end else begin
                nxt_st.onceCnt = st_ff.onceCnt + 5'h01;
            end
        end
        if (commit && pwrite) begin
            unique case (paddr)
                `AGC_A_CTRL: begin
                    // code 3 is not a mode and leaves the mode alone
                    if (pwdata[`AGC_F_MODE] <= 2'(AGCSW_CONT)) begin
                        nxt_st.mode = agcsw_mode_t'(pwdata[`AGC_F_MODE]);
                        nxt_st.onceCnt = '0;
                    end
                    nxt_st.fmt12 = pwdata[`AGC_F_FMT12];
                    nxt_st.bin = pwdata[`AGC_F_BIN];
                    nxt_st.noLim = pwdata[`AGC_F_NOLIM];
                    nxt_st.prof = pwdata[`AGC_F_PROF];
                end
                `AGC_A_SEL:   nxt_st.sel = pwdata[0];
                // no alignment mask: any single column or row is taken
                `AGC_A_WPOS: begin
                    nxt_st.win[st_ff.sel].x = pwdata[CW-1:0];
                    nxt_st.win[st_ff.sel].y = pwdata[`AGC_HI_LSB +: CW];
                end
                `AGC_A_WSIZE: begin
                    nxt_st.win[st_ff.sel].w = pwdata[CW-1:0];
                    nxt_st.win[st_ff.sel].h = pwdata[`AGC_HI_LSB +: CW];
                end
                `AGC_A_OPOS: begin
                    nxt_st.owin.x = pwdata[CW-1:0];
                    nxt_st.owin.y = pwdata[`AGC_HI_LSB +: CW];
                end
                `AGC_A_OSIZE: begin
                    nxt_st.owin.w = pwdata[CW-1:0];
                    nxt_st.owin.h = pwdata[`AGC_HI_LSB +: CW];
                end
                // limits clamp to the range legal for the present setup
                `AGC_A_LIMIT: begin
                    nxt_st.floorG = GW'(clampTo(pwdata[15:0], 16'(gainMax(st_ff.fmt12,
                                    st_ff.bin, st_ff.noLim))));
                    nxt_st.ceilG = GW'(clampTo(pwdata[`AGC_HI_LSB +: 16],
                                   16'(gainMax(st_ff.fmt12, st_ff.bin, st_ff.noLim))));
                end
                `AGC_A_TARGET: begin
                    nxt_st.target = DW'(clampTo(pwdata[15:0], st_ff.fmt12 ?
                                    16'(`AGC_TMAX_12) : 16'(`AGC_TMAX_8)));
                end
                `AGC_A_MANUAL: begin
                    nxt_st.manual = pwdata[GW-1:0];
                    if (st_ff.mode == AGCSW_OFF)
                        nxt_st.pend = pwdata[GW-1:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn)
            st_ff <= RST_ST;
        else
            st_ff <= nxt_st;
    end

    assign prdata           = st_ff.prdata;
    assign pready           = st_ff.pready;
    assign pslverr          = st_ff.pslverr;
    assign gainCode         = st_ff.gain;
    assign autoMode         = st_ff.mode;
    assign minimizeExposure = st_ff.prof;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_setupPhase;
        psel && penable && !pready;
    endsequence

    sequence s_accessDone;
        psel && penable && pready;
    endsequence

    AST_APB_ONE_WAIT: assert property (s_setupPhase |=> pready)
        else $error("apb answer not one cycle after access start");
    AST_RESET_WINDOW: assert property (disable iff (1'b0)
        !rstn |=> st_ff.win[0].x == '0 && st_ff.win[0].w == SENSOR_W
                  && st_ff.win[1].h == SENSOR_H && st_ff.owin.y == '0)
        else $error("window not full sensor after reset");
    AST_GAIN_AT_FRAME: assert property ($changed(gainCode) |-> $past(frameStart))
        else $error("gain code changed away from frame start");
    AST_GAIN_IN_LIMITS: assert property (
        link.stepValid && ovl && doAdj && st_ff.floorG <= st_ff.ceilG && !commit
        |=> st_ff.pend >= st_ff.floorG && st_ff.pend <= st_ff.ceilG)
        else $error("auto gain outside floor and ceiling");
    AST_MANUAL_NO_OVL: assert property (
        frameStart && autoMode != AGCSW_OFF && !ovl && !commit
        |=> st_ff.pend == $past(st_ff.manual))
        else $error("manual gain not used without overlap");
    AST_ONCE_LIMIT: assert property (
        onceTick && st_ff.onceCnt == `AGC_ONCE_MAX - 5'h01 && !(commit && pwrite)
        |=> autoMode == AGCSW_OFF)
        else $error("once mode ran past thirty images");
    AST_ONCE_MATCH: assert property (
        autoMode == AGCSW_ONCE && link.stepValid && ovl && link.matched
        && !(commit && pwrite) |=> autoMode == AGCSW_OFF)
        else $error("once mode kept running after match");
    AST_SLOW_SKIP: assert property (
        autoMode == AGCSW_CONT && st_ff.fast && !st_ff.parity && link.stepValid
        && !frameStart && !commit |=> $stable(st_ff.pend))
        else $error("fast rate adjusted on a skipped image");
    AST_TARGET_RANGE: assert property (
        s_accessDone ##0 (pwrite && paddr == `AGC_A_TARGET && !st_ff.fmt12)
        |=> st_ff.target <= DW'(`AGC_TMAX_8))
        else $error("8-bit target above 255");
    AST_LIMIT_LEGAL: assert property (
        s_accessDone ##0 (pwrite && paddr == `AGC_A_LIMIT)
        |=> st_ff.ceilG <= gainMax(st_ff.fmt12, st_ff.bin, st_ff.noLim))
        else $error("ceiling above legal range");
endmodule : agcsw_top
`default_nettype wire

//--- test_auto_gain_stat_window.sv
`timescale 1ns/1ps
`default_nettype none
`include "agcsw_cfg.svh"
module test_auto_gain_stat_window
    import agcsw_pkg::*;
;
    localparam logic [31:0] FULL   = {4'h0, `AGC_SENSOR_H, 4'h0, `AGC_SENSOR_W};
    localparam logic [31:0] CTL[4] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0040, 32'h0000_0010};
    localparam logic [9:0]  LIM[4] = '{`AGC_GMAX_8, `AGC_GMAX_BIN, `AGC_GMAX_ABS, `AGC_GMAX_12};
    logic        clk, rstn, psel, penable, pwrite, frameStart, lineEnd, pixValid;
    logic        pready, pslverr, minimizeExposure, err, prevFs, prevRstn;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] pixData;
    logic [9:0]  gainCode, prevG;
    agcsw_mode_t autoMode;
    int          failCount, numChecks, cycles;
    int          gap = 30;

    // short frame threshold: 65-cycle frames adjust every image, 40-cycle frames every other
    agcsw_top #(.FAST_FRAME_CYC(50)) agcsw_top_inst (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frameStart(frameStart), .lineEnd(lineEnd),
        .pixValid(pixValid), .pixData(pixData), .gainCode(gainCode),
        .autoMode(autoMode), .minimizeExposure(minimizeExposure));

    task automatic stopTest();
        if (failCount == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stopTest

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // request held until pready is sampled high, released after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rc

    // 4x8 frame; window 0 pixels ramp by 2 per column, the rest are decoys
    task automatic frames(input int v, input int n);
        repeat (n) begin
            @(posedge clk);
            frameStart <= 1'b1;
            @(posedge clk);
            frameStart <= 1'b0;
            for (int r = 0; r < 4; r++) begin
                for (int c = 0; c < 8; c++) begin
                    @(posedge clk);
                    pixValid <= 1'b1;
                    lineEnd  <= (c == 7);
                    pixData  <= (c >= 2 && c < 5 && r >= 1 && r < 3)
                                ? 12'(v + 2 * (c - 2)) : 12'h7FF;
                end
            end
            @(posedge clk);
            pixValid <= 1'b0;
            lineEnd  <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask : frames

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // hang guard; gain may only move right after a frame boundary
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            stopTest();
        end
        if (rstn && prevRstn && gainCode !== prevG) chk(prevFs, 1'b1);
        prevG = gainCode;
        prevFs = frameStart;
        prevRstn = rstn;
    end

    initial begin
        {rstn, psel, penable, pwrite, frameStart, lineEnd, pixValid} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pixData = 12'h000;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        chk(gainCode, 10'h000);
        chk(autoMode, AGCSW_OFF);
        rc(`AGC_A_WPOS, 32'h0000_0000);
        rc(`AGC_A_WSIZE, FULL);
        rc(`AGC_A_OSIZE, FULL);
        rc(`AGC_A_LIMIT, {6'h00, `AGC_GMAX_8, 16'h0000});
        rc(`AGC_A_TARGET, {20'h0_0000, `AGC_TGT_RST});
        wr(`AGC_A_SEL, 32'h0000_0001);
        rc(`AGC_A_WSIZE, FULL);
        wr(`AGC_A_WPOS, 32'h0006_0008);
        rc(`AGC_A_WPOS, 32'h0006_0008);
        wr(`AGC_A_SEL, 32'h0000_0000);
        rc(`AGC_A_WPOS, 32'h0000_0000);
        wr(`AGC_A_WPOS, 32'h0001_0002);
        wr(`AGC_A_WSIZE, 32'h0002_0003);
        rc(`AGC_A_WSIZE, 32'h0002_0003);
        rc(8'h28, 32'h0000_0000);
        chk(err, 1'b1);
        rc(8'h02, 32'h0000_0000);
        chk(err, 1'b1);
        foreach (CTL[i]) begin
            wr(`AGC_A_CTRL, CTL[i]);
            wr(`AGC_A_LIMIT, 32'h03FF_0000);
            rc(`AGC_A_LIMIT, {6'h00, LIM[i], 16'h0000});
        end
        wr(`AGC_A_TARGET, 32'h0000_0FFF);
        rc(`AGC_A_TARGET, {20'h0_0000, `AGC_TMAX_12});
        wr(`AGC_A_CTRL, 32'h0000_0000);
        wr(`AGC_A_TARGET, 32'h0000_0FFF);
        rc(`AGC_A_TARGET, {20'h0_0000, `AGC_TMAX_8});
        wr(`AGC_A_LIMIT, 32'h0057_0054);
        wr(`AGC_A_TARGET, 32'h0000_0080);
        wr(`AGC_A_MANUAL, 32'h0000_0055);
        frames(10, 2);
        chk(gainCode, 10'h055);
        // mean 12 stays below target, so gain climbs and sticks at the ceiling
        wr(`AGC_A_CTRL, 32'h0000_0002);
        frames(10, 8);
        chk(gainCode, 10'h057);
        rc(`AGC_A_STATUS, 32'h000C_0057);
        wr(`AGC_A_OPOS, 32'h0000_0003);
        frames(10, 2);
        rc(`AGC_A_STATUS, 32'h000D_0057);
        wr(`AGC_A_CTRL, 32'h0000_0003);
        @(posedge clk);
        chk(autoMode, AGCSW_CONT);
        // unreachable target: once mode gives up after its image budget
        wr(`AGC_A_CTRL, 32'h0000_0001);
        frames(4000, 26);
        chk(autoMode, AGCSW_ONCE);
        frames(4000, 8);
        chk(autoMode, AGCSW_OFF);
        chk(gainCode, 10'h054);
        wr(`AGC_A_TARGET, 32'h0000_000D);
        wr(`AGC_A_CTRL, 32'h0000_0001);
        frames(10, 4);
        chk(autoMode, AGCSW_OFF);
        // 40-cycle frames are fast: of 8 low means only every other one steps
        gap = 5;
        wr(`AGC_A_LIMIT, 32'h0060_0054);
        wr(`AGC_A_CTRL, 32'h0000_0002);
        frames(0, 10);
        chk(gainCode, 10'h058);
        // output window cols 0..1 miss window 0; the manual write alone moves nothing
        wr(`AGC_A_OPOS, 32'h0000_0000);
        wr(`AGC_A_OSIZE, 32'h0438_0002);
        wr(`AGC_A_MANUAL, 32'h0000_0056);
        frames(10, 3);
        chk(gainCode, 10'h056);
        wr(`AGC_A_CTRL, 32'h0000_0100);
        @(posedge clk);
        chk(minimizeExposure, 1'b1);
        chk(autoMode, AGCSW_OFF);
        stopTest();
    end
endmodule : test_auto_gain_stat_window
`default_nettype wire
